/* File: verilog/frso_pkg.sv */
// Constants, field layout, carrier types and the check-remainder function of the fault readback block
package frso_pkg;

    localparam int              CH_NUM      = 8;
    localparam int              RB_WIDTH    = 24;
    localparam int              OCP_MSB     = 23;
    localparam int              OCP_LSB     = 16;
    localparam int              OS_MSB      = 15;
    localparam int              OS_LSB      = 8;
    localparam int              UNDEF_BIT   = 7;
    localparam int              THERMAL_BIT = 6;
    localparam int              CRC_WIDTH   = 6;
    localparam int              CFG_WIDTH   = 8;
    localparam int              DIV_WIDTH   = CFG_WIDTH + CRC_WIDTH;
    localparam logic [6:0]      CRC_POLY    = 7'h43;
    localparam logic [7:0]      CFG_RESET   = 8'h00;
    localparam logic [23:0]     RB_RESET    = 24'h00_0000;
    localparam logic            UNDEF_VALUE = 1'b0;
    localparam int              SYNC_STAGES = 3;
    localparam int              BUF_DEPTH   = 2;
    localparam logic [1:0]      BUF_FULL    = 2'h2;

    // Fault detector levels as seen by the core
    typedef struct packed {
        logic [CH_NUM-1:0] ocp;
        logic [CH_NUM-1:0] openShort;
        logic              thermal;
    } frso_fault_t;

    // Readback word, msb shifted out first
    typedef struct packed {
        logic [CH_NUM-1:0]    ocp;
        logic [CH_NUM-1:0]    openShort;
        logic                 undefBit;
        logic                 thermal;
        logic [CRC_WIDTH-1:0] crc;
    } frso_rdbk_t;

    // Long division of a 14-bit dividend by the generator; returns the 6-bit remainder
    function automatic logic [CRC_WIDTH-1:0] frso_crc_rem(input logic [DIV_WIDTH-1:0] dividend);
        logic [DIV_WIDTH-1:0] rem;
        rem = dividend;
        for (int i = DIV_WIDTH - 1; i >= CRC_WIDTH; i--) begin
            if (rem[i]) begin
                rem[i-:7] = rem[i-:7] ^ CRC_POLY;
            end
        end
        return rem[CRC_WIDTH-1:0];
    endfunction

endpackage

/* File: verilog/frso_top.sv */
// Fault readback register, check remainder and serial shift path of the eight-channel driver
`timescale 1ns/1ns
module frso_top
(
    input  wire logic                ref_clk,
    input  wire logic                rst_n,
    input  wire logic                shiftClk,
    input  wire logic                serialIn,
    input  wire logic                latchIn,
    input  wire frso_pkg::frso_fault_t faultIn,
    output logic                     serialOut,
    output logic [frso_pkg::CH_NUM-1:0] chanDrive
);
    import frso_pkg::*;

    localparam int SYNC_W = $bits(frso_fault_t) + 1 + CFG_WIDTH;

    // ---------------- Link domain (shift clock) ----------------
    logic [CFG_WIDTH-1:0] cfgShift_q, cfgShift_d;
    logic [RB_WIDTH-1:0]  rbShift_q, rbShift_d;
    logic                 ackTog_q, ackTog_d;
    logic [2:0]           reqSync_q;
    logic                 serialOut_q;
    logic                 reqTog_q;
    frso_rdbk_t           headWord;
    logic                 linkLoad;

    always_comb begin
        linkLoad   = (reqSync_q[1] == reqSync_q[2]) && (reqSync_q[2] != ackTog_q);
        cfgShift_d = {cfgShift_q[CFG_WIDTH-2:0], serialIn};
        ackTog_d   = linkLoad ? reqSync_q[2] : ackTog_q;
        // Upstream readback follows our own word through the chain
        rbShift_d  = linkLoad ? headWord : {rbShift_q[RB_WIDTH-2:0], serialIn};
    end

    always_ff @(posedge shiftClk or negedge rst_n) begin
        if (!rst_n) begin
            cfgShift_q <= CFG_RESET;
            rbShift_q  <= RB_RESET;
            ackTog_q   <= 1'b0;
            reqSync_q  <= 3'h0;
        end else begin
            cfgShift_q <= cfgShift_d;
            rbShift_q  <= rbShift_d;
            ackTog_q   <= ackTog_d;
            reqSync_q  <= {reqSync_q[1:0], reqTog_q};
        end
    end

    // Falling edge launch buys the next device a half period of hold
    always_ff @(negedge shiftClk or negedge rst_n) begin
        if (!rst_n) begin
            serialOut_q <= 1'b0;
        end else begin
            serialOut_q <= rbShift_q[RB_WIDTH-1];
        end
    end

    assign serialOut = serialOut_q;

    // ---------------- Core domain (ref_clk) ----------------
    // Three-stage synchronisers; a change is accepted once stages two and three agree
    logic [SYNC_W-1:0] syncA_q, syncB_q, syncC_q, filt_q, filt_d;
    frso_fault_t       faultLvl;
    logic              latchLvl;
    logic [CFG_WIDTH-1:0] cfgSeen;

    always_comb begin
        filt_d = ((syncB_q ~^ syncC_q) & syncC_q) | ((syncB_q ^ syncC_q) & filt_q);
        {faultLvl, latchLvl, cfgSeen} = filt_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            syncA_q <= '0;
            syncB_q <= '0;
            syncC_q <= '0;
            filt_q  <= '0;
        end else begin
            syncA_q <= {faultIn, latchIn, cfgShift_q};
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
            filt_q  <= filt_d;
        end
    end

    // Sticky flags, snapshot request and storage register
    frso_fault_t          flags_q, flags_d;
    logic                 latchPrev_q, snapWant_q, snapWant_d;
    logic [CH_NUM-1:0]    chanDrive_q, chanDrive_d;
    logic                 latchRise, bufReady, snapTake;
    logic [1:0]           bufCount_q, bufCount_d;
    frso_rdbk_t           snapWord;

    always_comb begin
        latchRise   = latchLvl && !latchPrev_q;
        bufReady    = (bufCount_q != BUF_FULL);
        // A full buffer holds the read back, so no flag is cleared unseen
        snapTake    = snapWant_q && bufReady;
        snapWant_d  = latchRise | (snapWant_q & ~snapTake);
        chanDrive_d = latchRise ? cfgSeen : chanDrive_q;
        snapWord.ocp       = flags_q.ocp;
        snapWord.openShort = flags_q.openShort;
        snapWord.undefBit  = UNDEF_VALUE;
        snapWord.thermal   = flags_q.thermal;
        snapWord.crc       = frso_crc_rem({cfgSeen, {CRC_WIDTH{1'b0}}});
        // New events in the clearing cycle survive the clear
        flags_d = (snapTake ? frso_fault_t'('0) : flags_q) | faultLvl;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_q     <= '0;
            latchPrev_q <= 1'b0;
            snapWant_q  <= 1'b0;
            chanDrive_q <= CFG_RESET;
        end else begin
            flags_q     <= flags_d;
            latchPrev_q <= latchLvl;
            snapWant_q  <= snapWant_d;
            chanDrive_q <= chanDrive_d;
        end
    end

    assign chanDrive = chanDrive_q;

    // Two-entry buffer, drained by a toggle handshake with the link side
    frso_rdbk_t bufMem_q [BUF_DEPTH];
    frso_rdbk_t bufMem_d [BUF_DEPTH];
    logic       wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d, pend_q, pend_d, reqTog_d;
    logic [2:0] ackSync_q;
    logic       bufPop;

    always_comb begin
        bufMem_d = bufMem_q;
        wrPtr_d  = wrPtr_q;
        rdPtr_d  = rdPtr_q;
        pend_d   = pend_q;
        reqTog_d = reqTog_q;
        bufPop   = pend_q && (ackSync_q[1] == ackSync_q[2]) && (ackSync_q[2] == reqTog_q);
        if (snapTake) begin
            bufMem_d[wrPtr_q] = snapWord;
            wrPtr_d = ~wrPtr_q;
        end
        if (bufPop) begin
            rdPtr_d = ~rdPtr_q;
            pend_d  = 1'b0;
        end else if (!pend_q && bufCount_q != 2'h0) begin
            reqTog_d = ~reqTog_q;
            pend_d   = 1'b1;
        end
        bufCount_d = bufCount_q + {1'b0, snapTake} - {1'b0, bufPop};
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bufMem_q[0] <= RB_RESET;
            bufMem_q[1] <= RB_RESET;
            wrPtr_q     <= 1'b0;
            rdPtr_q     <= 1'b0;
            pend_q      <= 1'b0;
            reqTog_q    <= 1'b0;
            bufCount_q  <= 2'h0;
            ackSync_q   <= 3'h0;
        end else begin
            bufMem_q    <= bufMem_d;
            wrPtr_q     <= wrPtr_d;
            rdPtr_q     <= rdPtr_d;
            pend_q      <= pend_d;
            reqTog_q    <= reqTog_d;
            bufCount_q  <= bufCount_d;
            ackSync_q   <= {ackSync_q[1:0], ackTog_q};
        end
    end

    // Held stable by the handshake while the link side may load it
    assign headWord = bufMem_q[rdPtr_q];

    // ---------------- Checks ----------------
    // Separate record of a thermal event since the last read, for chk_thermal_flag_word
    logic thermalSeen_q, thermalSeen_d;

    always_comb begin
        thermalSeen_d = faultLvl.thermal | (thermalSeen_q & ~snapTake);
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            thermalSeen_q <= 1'b0;
        end else begin
            thermalSeen_q <= thermalSeen_d;
        end
    end

    sequence s_take;
        snapTake;
    endsequence

    sequence s_cleared_after_take;
        ##1 (flags_q.ocp == $past(faultLvl.ocp));
    endsequence

    sequence s_latch_rise;
        latchRise;
    endsequence

    sequence s_link_load;
        linkLoad;
    endsequence

    chk_ocp_set_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !snapTake |=> ((flags_q.ocp & $past(flags_q.ocp | faultLvl.ocp)) == $past(flags_q.ocp | faultLvl.ocp)))
        else $error("over-current flag lost without a read");

    chk_ocp_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_take |-> s_cleared_after_take)
        else $error("over-current flags not cleared by read");

    chk_os_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake |-> (snapWord.openShort == flags_q.openShort) ##1 (flags_q.openShort == $past(faultLvl.openShort)))
        else $error("open-short flags wrong across read");

    chk_thermal_flag_word: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake |-> (snapWord.thermal == thermalSeen_q))
        else $error("thermal flag missing from readback");

    chk_crc_field_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake |-> (snapWord.crc == frso_crc_rem({cfgSeen, 6'h00})))
        else $error("check remainder field wrong");

    chk_crc_zero_residual: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake |-> (frso_crc_rem({cfgSeen, snapWord.crc}) == 6'h00))
        else $error("check remainder residual not zero");

    chk_undef_bit_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake |=> (bufMem_q[$past(wrPtr_q)].undefBit == 1'b0))
        else $error("undefined readback bit not zero");

    chk_serial_out_falling: assert property (@(negedge shiftClk) disable iff (!rst_n)
        1'b1 |=> (serialOut_q == $past(rbShift_q[RB_WIDTH-1])))
        else $error("serial output not launched on falling edge");

    chk_sipo_history: assert property (@(posedge shiftClk) disable iff (!rst_n)
        1'b1 ##8 1'b1 |-> (cfgShift_q[7] == $past(serialIn, 8)) && (cfgShift_q[0] == $past(serialIn)))
        else $error("configuration shift register lost a bit");

    chk_buf_full_stall: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bufCount_q == BUF_FULL) |-> !snapTake ##1 (bufCount_q != 2'h3))
        else $error("buffer overfilled");

    chk_os_set_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !snapTake |=> ((flags_q.openShort & $past(flags_q.openShort | faultLvl.openShort))
            == $past(flags_q.openShort | faultLvl.openShort)))
        else $error("open-short flag lost without a read");

    chk_thermal_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !snapTake && (flags_q.thermal || faultLvl.thermal) |=> flags_q.thermal)
        else $error("thermal flag lost without a read");

    chk_crc_known_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        snapTake && (cfgSeen == 8'hFF) |-> (snapWord.crc == 6'h0D))
        else $error("check remainder of an all-ones configuration wrong");

    chk_drive_on_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_latch_rise |=> (chanDrive_q == $past(cfgSeen)))
        else $error("channel drive not loaded on latch");

    chk_drive_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !latchRise |=> (chanDrive_q == $past(chanDrive_q)))
        else $error("channel drive changed without a latch");

    chk_snap_after_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_latch_rise ##1 bufReady |-> snapTake)
        else $error("snapshot not taken after latch");

    chk_head_stable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pend_q && !bufPop |=> (headWord == $past(headWord)))
        else $error("buffer head moved while the link may load it");

    chk_req_when_pend: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reqTog_q != $past(reqTog_q)) |-> pend_q)
        else $error("request toggled without a pending word");

    chk_filter_agree: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1 |=> (((filt_q ^ $past(filt_q)) & ~$past(syncB_q ~^ syncC_q)) == {SYNC_W{1'b0}}))
        else $error("input accepted before two stages agreed");

    chk_link_load_once: assert property (@(posedge shiftClk) disable iff (!rst_n)
        s_link_load |=> !linkLoad)
        else $error("one request loaded twice");

    chk_ack_on_load: assert property (@(posedge shiftClk) disable iff (!rst_n)
        (ackTog_q != $past(ackTog_q)) |-> $past(linkLoad))
        else $error("acknowledge toggled without a load");

endmodule // frso_top

/* File: tb/frso_host.sv */
// Host model: drives shift clock frames and serial data, captures the serial output
`timescale 1ns/1ns
module frso_host (
    output logic      shiftClk,
    output logic      serialIn,
    input  wire logic serialOut
);
    initial begin
        shiftClk = 1'b0;
        serialIn = 1'b0;
    end

    // Clock stands low between frames; data moves only while the clock is low
    task automatic frame(input logic [31:0] din, output logic [31:0] cap, output logic [31:0] capHi);
        for (int i = 31; i >= 0; i--) begin
            serialIn = din[i];
            #80;
            // Sampled late in the low phase, after the falling edge update settled
            cap[i] = serialOut;
            shiftClk = 1'b1;
            #80;
            // Same bit late in the high phase, since only the falling edge may launch
            capHi[i] = serialOut;
            shiftClk = 1'b0;
        end
        serialIn = ~serialIn;
    endtask
endmodule // frso_host

/* File: tb/frso_top_bench.sv */
// Self-checking bench of the fault readback block against a queue based reference model
`timescale 1ns/1ns
module frso_top_bench;
    import frso_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        latchIn = 1'b0;
    frso_fault_t faultIn = '0;
    logic        shiftClk;
    logic        serialIn;
    logic        serialOut;
    logic [7:0]  chanDrive;
    int          fails      = 0;
    int          checkCount = 0;
    int          cycles     = 0;
    int          ocp        = 0;
    int          os         = 0;
    int          thermal    = 0;
    int          words[$];

    always #50 ref_clk = ~ref_clk;

    frso_top i_dut (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .shiftClk (shiftClk),
        .serialIn (serialIn),
        .latchIn  (latchIn),
        .faultIn  (faultIn),
        .serialOut(serialOut),
        .chanDrive(chanDrive)
    );

    frso_host i_host (
        .shiftClk (shiftClk),
        .serialIn (serialIn),
        .serialOut(serialOut)
    );

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic endOfTest();
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            endOfTest();
        end
    end

    // Long division of a 14-bit value by the generator
    function automatic int rem(input int d);
        for (int b = 13; b >= 6; b--) begin
            if (d[b]) begin
                d ^= 32'h0000_0043 << (b - 6);
            end
        end
        return d & 32'h0000_003F;
    endfunction

    // Shifts a new configuration in; the clock stood still, so the fourth edge loads and bit 27 holds bit 23
    task automatic readFrame(input logic [7:0] cfg);
        logic [31:0] cap;
        logic [31:0] capHi;
        logic [23:0] seen;
        int          exp;
        @(posedge ref_clk);
        #37;
        i_host.frame({24'h00_0000, cfg}, cap, capHi);
        if (words.size() > 0) begin
            exp = words.pop_front();
            seen = cap[27 -: 24];
            check("readback", seen, exp[23:0]);
            check("launchEdge", capHi[27 -: 24], exp[23:0]);
            check("residual", 24'(rem({exp[31:24], seen[5:0]})), 24'h00_0000);
        end
    endtask

    task automatic snap(input logic [7:0] cfg, input logic [16:0] fv);
        repeat (6) @(posedge ref_clk);
        faultIn <= fv;
        repeat (8) @(posedge ref_clk);
        faultIn <= '0;
        ocp |= fv[16:9];
        os |= fv[8:1];
        thermal |= fv[0];
        repeat (6) @(posedge ref_clk);
        latchIn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        latchIn <= 1'b0;
        words.push_back((int'(cfg) << 24) | (ocp << 16) | (os << 8) | (thermal << 6) | rem(int'(cfg) << 6));
        // Read clears every flag
        ocp = 0;
        os = 0;
        thermal = 0;
        repeat (12) @(posedge ref_clk);
        check("chanDrive", 24'(chanDrive), 24'(cfg));
    endtask

    initial begin
        logic [7:0]  cfg;
        logic [16:0] fv;
        void'($urandom(37705));
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        cfg = 8'hFF;
        readFrame(cfg);
        // Odd tests inject nothing, so a stale flag would show up there
        for (int t = 0; t < 8; t++) begin
            fv = t[0] ? 17'h0_0000 : 17'($urandom);
            snap(cfg, fv);
            cfg = 8'($urandom);
            readFrame(cfg);
            $display("test %0d done, mismatches %0d", t, fails);
        end
        endOfTest();
    end
endmodule // frso_top_bench
